// file: hdl/eep_defines.svh
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// Device address map on the byte bus.
`define EEP_ARR_BASE   16'h0800
`define EEP_ARR_LAST   16'h09FF
`define EEP_NVR_ADDR   16'hFE1C
`define EEP_CTL_ADDR   16'hFE1D
`define EEP_ACR_ADDR   16'hFE1F

// Control register bit positions.
`define EEP_CTL_PGM    0
`define EEP_CTL_LAT    2
`define EEP_CTL_RAS0   3
`define EEP_CTL_RAS1   4
`define EEP_CTL_OFF    5
`define EEP_CTL_BCLK   7

// Reset and factory values.
`define EEP_CELL_BLANK 8'hFF
`define EEP_NVR_INIT   8'h10
`define EEP_ACR_RST    8'h00
`define EEP_PROT_LSB   0
`define EEP_BLK_LSB    7

// Host register offsets on APB (byte addresses).
`define EEP_R_CMD      8'h00
`define EEP_R_ADDR     8'h04
`define EEP_R_DATA     8'h08
`define EEP_R_HOLD     8'h0C
`define EEP_R_FALL     8'h10
`define EEP_R_STAT     8'h14

// Command register fields.
`define EEP_CMD_OP_LSB 0
`define EEP_CMD_ES_LSB 4
`define EEP_CMD_GO     8

// Default wait counts in core clock cycles.
`define EEP_HOLD_RST   16'h0010
`define EEP_FALL_RST   16'h0008
`endif

// file: hdl/eep_pkg.sv
package eep_pkg;
    // Operations that software can start in the host controller.
    typedef enum logic [1:0] {
        EEP_OP_SEQ,
        EEP_OP_READ,
        EEP_OP_RAW,
        EEP_OP_NONE
    } eep_op_t;

    // Erase select field values.
    typedef enum logic [1:0] {
        EEP_M_PROG,
        EEP_M_BYTE_ERASE,
        EEP_M_BLOCK_ERASE,
        EEP_M_BULK_ERASE
    } eep_mode_t;

    // Host sequencer states.
    typedef enum logic [3:0] {
        EEP_H_IDLE,
        EEP_H_SETUP,
        EEP_H_DATA,
        EEP_H_PGM_ON,
        EEP_H_HOLD,
        EEP_H_PGM_OFF,
        EEP_H_FALL,
        EEP_H_LAT_OFF,
        EEP_H_READ,
        EEP_H_RWAIT,
        EEP_H_RAW
    } eep_hstate_t;
endpackage

// file: hdl/eep_bus_if.sv
`timescale 1ns/10ps
// Byte-wide register and array bus between the host and the array block.
interface eep_bus_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rdata_vld;

    modport dev (
        input  wr_stb,
        input  rd_stb,
        input  addr,
        input  wdata,
        output rdata,
        output rdata_vld
    );

    modport host (
        output wr_stb,
        output rd_stb,
        output addr,
        output wdata,
        input  rdata,
        input  rdata_vld
    );
endinterface

// file: hdl/eep_array_dev.sv
`timescale 1ns/10ps
`include "eep_defines.svh"
// Array block: 512 cells, control register, nonvolatile and volatile
// configuration registers, and the charge pump switch.
module eep_array_dev (
    input  wire logic core_clk,
    input  wire logic rstn,
    eep_bus_if.dev    bus,
    output wire logic pump_on,
    output wire logic [7:0] config_copy,
    output wire logic [1:0] erase_mode,
    output wire logic array_off
);

    // Factory state: every cell blank, configuration unprotected. These
    // are declaration initialisers, so the cell process stays the only
    // writer of the cells and of the nonvolatile byte.
    // erased start state
    logic [7:0]  cell_mem [0:511] = '{default: `EEP_CELL_BLANK};
    logic [7:0]  nonvolatile_config_reg_ff = `EEP_NVR_INIT;
    logic [7:0]  volatile_config_copy_ff;
    logic        reload_ff;
    logic        bus_clk_sel_ff;
    logic        power_off_ff;
    logic [1:0]  erase_select_ff;
    logic        latch_enable_ff;
    logic        program_enable_ff;
    logic        latched_ff;
    logic        lat_nvr_ff;
    logic [8:0]  lat_addr_ff;
    logic [7:0]  lat_data_ff;
    logic        pump_on_ff;
    logic [7:0]  rdata_ff;
    logic        rdata_vld_ff;

    logic        in_array;
    logic        is_nvr;
    logic        is_ctl;
    logic        is_acr;
    logic        ctl_wr;
    logic        ctl_open;
    logic        capture;
    logic        blocked;
    logic        nxt_program_enable;
    logic        nxt_latch_enable;
    logic [1:0]  nxt_erase_select;
    logic        pgm_rise;
    logic [7:0]  array_ctl;
    logic [7:0]  cell_rd;

    // Address decode; only the 512-byte window counts as array.
    // array window decode
    assign in_array = (bus.addr >= `EEP_ARR_BASE) &&
                      (bus.addr <= `EEP_ARR_LAST);
    assign is_nvr   = (bus.addr == `EEP_NVR_ADDR);
    assign is_ctl   = (bus.addr == `EEP_CTL_ADDR);
    assign is_acr   = (bus.addr == `EEP_ACR_ADDR);
    assign ctl_wr   = bus.wr_stb && is_ctl;

    // While the latch is armed, the control register stays shut until a
    // valid target has been captured, so a stray control write cannot
    // disturb a sequence in progress.
    // control write gate
    assign ctl_open = !latch_enable_ff || latched_ff;

    // Next control values for an accepted control write.
    always_comb begin
        nxt_program_enable = program_enable_ff;
        nxt_latch_enable   = latch_enable_ff;
        nxt_erase_select   = erase_select_ff;
        if (ctl_wr && ctl_open) begin
            nxt_program_enable = bus.wdata[`EEP_CTL_PGM] &&
                                 latch_enable_ff && latched_ff;
            nxt_latch_enable   = bus.wdata[`EEP_CTL_LAT] ||
                                 program_enable_ff;
            // The mode is frozen once the pump is running.
            if (!program_enable_ff) begin
                nxt_erase_select = {bus.wdata[`EEP_CTL_RAS1],
                                    bus.wdata[`EEP_CTL_RAS0]};
            end
        end
    end

    assign pgm_rise = nxt_program_enable && !program_enable_ff;

    // Protection check against the latched target and the chosen mode.
    // block protection
    always_comb begin
        blocked = 1'b0;
        if (!lat_nvr_ff) begin
            unique case (nxt_erase_select)
                2'b11:
                    blocked = |volatile_config_copy_ff[`EEP_PROT_LSB +: 4];
                default:
                    blocked = volatile_config_copy_ff[`EEP_PROT_LSB +
                                  lat_addr_ff[`EEP_BLK_LSB +: 2]];
            endcase
        end
    end

    // Control register state.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus_clk_sel_ff    <= 1'b0;
            power_off_ff      <= 1'b0;
            erase_select_ff   <= 2'b00;
            latch_enable_ff   <= 1'b0;
            program_enable_ff <= 1'b0;
        end else begin
            if (ctl_wr && ctl_open) begin
                bus_clk_sel_ff <= bus.wdata[`EEP_CTL_BCLK];
                power_off_ff   <= bus.wdata[`EEP_CTL_OFF];
            end
            erase_select_ff   <= nxt_erase_select;
            latch_enable_ff   <= nxt_latch_enable;
            program_enable_ff <= nxt_program_enable;
        end
    end

    // Capture of target address and data; the program bit must be clear so that a
    // write during programming cannot move the target under the voltage.
    // latch capture
    assign capture = latch_enable_ff && !program_enable_ff &&
                     bus.wr_stb && (in_array || is_nvr);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            latched_ff  <= 1'b0;
            lat_nvr_ff  <= 1'b0;
            lat_addr_ff <= 9'h000;
            lat_data_ff <= 8'h00;
        end else if (!latch_enable_ff) begin
            latched_ff <= 1'b0;
        end else if (capture) begin
            latched_ff  <= 1'b1;
            lat_nvr_ff  <= is_nvr;
            lat_addr_ff <= bus.addr[8:0];
            lat_data_ff <= bus.wdata;
        end
    end

    // Pump follows the program bit, but never powers a protected target.
    // pump switching
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pump_on_ff <= 1'b0;
        end else if (!nxt_program_enable) begin
            pump_on_ff <= 1'b0;
        end else if (pgm_rise) begin
            pump_on_ff <= !blocked;
        end
    end

    // Cell update at the moment the voltage is applied. Programming can
    // only pull bits low, so a second program of the same byte without an
    // erase cannot restore ones.
    // only valid targets change
    always_ff @(posedge core_clk) begin
        if (pgm_rise && !blocked) begin
            unique case (nxt_erase_select)
                2'b00: begin
                    if (lat_nvr_ff) begin
                        nonvolatile_config_reg_ff <=
                            nonvolatile_config_reg_ff & lat_data_ff;
                    end else begin
                        cell_mem[lat_addr_ff] <=
                            cell_mem[lat_addr_ff] & lat_data_ff;
                    end
                end
                2'b01: begin
                    if (lat_nvr_ff) begin
                        nonvolatile_config_reg_ff <= `EEP_CELL_BLANK;
                    end else begin
                        cell_mem[lat_addr_ff] <= `EEP_CELL_BLANK;
                    end
                end
                2'b10: begin
                    for (int i = 0; i < 512; i++) begin
                        if (!lat_nvr_ff && (i[8:7] ==
                                lat_addr_ff[`EEP_BLK_LSB +: 2])) begin
                            cell_mem[i] <= `EEP_CELL_BLANK;
                        end
                    end
                end
                2'b11: begin
                    for (int i = 0; i < 512; i++) begin
                        if (!lat_nvr_ff) begin
                            cell_mem[i] <= `EEP_CELL_BLANK;
                        end
                    end
                end
            endcase
        end
    end

    // Volatile copy loads once after reset and again on every read of the
    // nonvolatile register; the copy, not the cells, steers protection.
    // configuration reload
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reload_ff               <= 1'b1;
            volatile_config_copy_ff <= `EEP_ACR_RST;
        end else begin
            reload_ff <= 1'b0;
            if (reload_ff || (bus.rd_stb && is_nvr)) begin
                volatile_config_copy_ff <= nonvolatile_config_reg_ff;
            end
        end
    end

    // Read view of the control register; unused bits read zero.
    always_comb begin
        array_ctl                = 8'h00;
        array_ctl[`EEP_CTL_BCLK] = bus_clk_sel_ff;
        array_ctl[`EEP_CTL_OFF]  = power_off_ff;
        array_ctl[`EEP_CTL_RAS1] = erase_select_ff[1];
        array_ctl[`EEP_CTL_RAS0] = erase_select_ff[0];
        array_ctl[`EEP_CTL_LAT]  = latch_enable_ff;
        array_ctl[`EEP_CTL_PGM]  = program_enable_ff;
    end

    // Array read, replaced by the latched byte for other locations.
    // latched data readback
    always_comb begin
        cell_rd = cell_mem[bus.addr[8:0]];
        if (latch_enable_ff && latched_ff &&
                (lat_nvr_ff || bus.addr[8:0] != lat_addr_ff)) begin
            cell_rd = lat_data_ff;
        end
    end

    // Read data answers one cycle after the strobe.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff     <= 8'h00;
            rdata_vld_ff <= 1'b0;
        end else begin
            rdata_vld_ff <= bus.rd_stb;
            if (bus.rd_stb) begin
                if (in_array) begin
                    rdata_ff <= cell_rd;
                end else if (is_nvr) begin
                    rdata_ff <= nonvolatile_config_reg_ff;
                end else if (is_ctl) begin
                    rdata_ff <= array_ctl;
                end else if (is_acr) begin
                    rdata_ff <= volatile_config_copy_ff;
                end else begin
                    rdata_ff <= 8'h00;
                end
            end
        end
    end

    assign bus.rdata     = rdata_ff;
    assign bus.rdata_vld = rdata_vld_ff;
    assign pump_on       = pump_on_ff;
    assign config_copy   = volatile_config_copy_ff;
    assign erase_mode    = erase_select_ff;
    assign array_off     = power_off_ff;

endmodule

// file: hdl/eep_host_ctl.sv
`timescale 1ns/10ps
`include "eep_defines.svh"
// Host controller: APB registers on one side, and the programming
// sequence driven onto the array bus on the other.
module eep_host_ctl (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    eep_bus_if.host          bus
);

    eep_pkg::eep_hstate_t state_ff;
    logic [1:0]  op_ff;
    logic [1:0]  es_ff;
    logic [15:0] addr_ff;
    logic [7:0]  data_ff;
    logic [15:0] hold_ff;
    logic [15:0] fall_ff;
    logic [15:0] cnt_ff;
    logic [7:0]  rd_byte_ff;
    logic        go_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        wr_ff;
    logic        rd_ff;
    logic [15:0] baddr_ff;
    logic [7:0]  bwdata_ff;
    logic        apb_wr;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [7:0]  ctl_word;

    assign apb_wr = psel && penable && pready_ff && pwrite;
    assign mapped = (paddr == `EEP_R_CMD) || (paddr == `EEP_R_ADDR) ||
                    (paddr == `EEP_R_DATA) || (paddr == `EEP_R_HOLD) ||
                    (paddr == `EEP_R_FALL) || (paddr == `EEP_R_STAT);

    // Read multiplexer for software.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `EEP_R_CMD:  rd_mux = {26'h0, es_ff, 2'h0, op_ff};
            `EEP_R_ADDR: rd_mux = {16'h0, addr_ff};
            `EEP_R_DATA: rd_mux = {24'h0, data_ff};
            `EEP_R_HOLD: rd_mux = {16'h0, hold_ff};
            `EEP_R_FALL: rd_mux = {16'h0, fall_ff};
            `EEP_R_STAT: rd_mux = {16'h0, rd_byte_ff, 7'h0,
                                   state_ff != eep_pkg::EEP_H_IDLE};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait cycle, then pready with registered data.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !mapped;
            prdata_ff  <= rd_mux;
        end
    end

    // Software registers; writes land at the edge that completes access.
    // configurable wait counts
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            op_ff   <= 2'b00;
            es_ff   <= 2'b00;
            addr_ff <= 16'h0000;
            data_ff <= 8'h00;
            hold_ff <= `EEP_HOLD_RST;
            fall_ff <= `EEP_FALL_RST;
            go_ff   <= 1'b0;
        end else begin
            go_ff <= apb_wr && (paddr == `EEP_R_CMD) &&
                     pwdata[`EEP_CMD_GO];
            if (apb_wr) begin
                unique case (paddr)
                    `EEP_R_CMD: begin
                        op_ff <= pwdata[`EEP_CMD_OP_LSB +: 2];
                        es_ff <= pwdata[`EEP_CMD_ES_LSB +: 2];
                    end
                    `EEP_R_ADDR: addr_ff <= pwdata[15:0];
                    `EEP_R_DATA: data_ff <= pwdata[7:0];
                    `EEP_R_HOLD: hold_ff <= pwdata[15:0];
                    `EEP_R_FALL: fall_ff <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Control word with the latch bit and the chosen mode.
    // mode and latch in one write
    assign ctl_word = ({7'h00, 1'b1} << `EEP_CTL_LAT) |
                      ({7'h00, es_ff[1]} << `EEP_CTL_RAS1) |
                      ({7'h00, es_ff[0]} << `EEP_CTL_RAS0);

    // Sequencer with one registered bus strobe per bus step; HOLD, FALL and RWAIT drive none. A go while busy
    // is dropped, since the array interlocks forbid overlapping sequences.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= eep_pkg::EEP_H_IDLE;
            cnt_ff     <= 16'h0000;
            wr_ff      <= 1'b0;
            rd_ff      <= 1'b0;
            baddr_ff   <= 16'h0000;
            bwdata_ff  <= 8'h00;
            rd_byte_ff <= 8'h00;
        end else begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            unique case (state_ff)
                eep_pkg::EEP_H_IDLE: begin
                    if (go_ff) begin
                        unique case (op_ff)
                            2'b00: state_ff <= eep_pkg::EEP_H_SETUP;
                            2'b01: state_ff <= eep_pkg::EEP_H_READ;
                            2'b10: state_ff <= eep_pkg::EEP_H_RAW;
                            default: state_ff <= eep_pkg::EEP_H_IDLE;
                        endcase
                    end
                end
                eep_pkg::EEP_H_SETUP: begin
                    wr_ff     <= 1'b1;
                    baddr_ff  <= `EEP_CTL_ADDR;
                    bwdata_ff <= ctl_word;
                    state_ff  <= eep_pkg::EEP_H_DATA;
                end
                eep_pkg::EEP_H_DATA: begin
                    wr_ff     <= 1'b1;
                    baddr_ff  <= addr_ff;
                    bwdata_ff <= data_ff;
                    state_ff  <= eep_pkg::EEP_H_PGM_ON;
                end
                eep_pkg::EEP_H_PGM_ON: begin
                    wr_ff     <= 1'b1;
                    baddr_ff  <= `EEP_CTL_ADDR;
                    bwdata_ff <= ctl_word | (8'h01 << `EEP_CTL_PGM);
                    cnt_ff    <= hold_ff;
                    state_ff  <= eep_pkg::EEP_H_HOLD;
                end
                eep_pkg::EEP_H_HOLD: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_ff <= 16'h0001) begin
                        state_ff <= eep_pkg::EEP_H_PGM_OFF;
                    end
                end
                eep_pkg::EEP_H_PGM_OFF: begin
                    wr_ff     <= 1'b1;
                    baddr_ff  <= `EEP_CTL_ADDR;
                    bwdata_ff <= ctl_word;
                    cnt_ff    <= fall_ff;
                    state_ff  <= eep_pkg::EEP_H_FALL;
                end
                eep_pkg::EEP_H_FALL: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_ff <= 16'h0001) begin
                        state_ff <= eep_pkg::EEP_H_LAT_OFF;
                    end
                end
                eep_pkg::EEP_H_LAT_OFF: begin
                    wr_ff     <= 1'b1;
                    baddr_ff  <= `EEP_CTL_ADDR;
                    bwdata_ff <= 8'h00;
                    state_ff  <= eep_pkg::EEP_H_IDLE;
                end
                eep_pkg::EEP_H_READ: begin
                    rd_ff    <= 1'b1;
                    baddr_ff <= addr_ff;
                    state_ff <= eep_pkg::EEP_H_RWAIT;
                end
                eep_pkg::EEP_H_RWAIT: begin
                    if (bus.rdata_vld) begin
                        rd_byte_ff <= bus.rdata;
                        state_ff   <= eep_pkg::EEP_H_IDLE;
                    end
                end
                eep_pkg::EEP_H_RAW: begin
                    wr_ff     <= 1'b1;
                    baddr_ff  <= addr_ff;
                    bwdata_ff <= data_ff;
                    state_ff  <= eep_pkg::EEP_H_IDLE;
                end
                default: state_ff <= eep_pkg::EEP_H_IDLE;
            endcase
        end
    end

    assign bus.wr_stb = wr_ff;
    assign bus.rd_stb = rd_ff;
    assign bus.addr   = baddr_ff;
    assign bus.wdata  = bwdata_ff;
    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;

endmodule

// file: testbench/eep_monitor.sv
`timescale 1ns/10ps
`include "eep_defines.svh"
// Watches the byte bus between the two ends and the pump switch.
module eep_monitor (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        rdata_vld,
    input wire logic        pump_on,
    input wire logic [7:0]  config_copy,
    input wire logic [1:0]  erase_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    wire logic ctl_wr;
    wire logic unmapped;

    // Decoded once so every property speaks of the same access.
    assign ctl_wr   = wr_stb && addr == `EEP_CTL_ADDR;
    assign unmapped = addr[15:9] != 7'h04 && addr[15:2] != 14'h3F87;

    // A read of the nonvolatile byte is answered on the next cycle.
    sequence s_nvr_rd;
        rd_stb && addr == `EEP_NVR_ADDR ##1 rdata_vld;
    endsequence

    a_pump_on_cause: assert property ($rose(pump_on) |->
        $past(ctl_wr && wdata[0])) else $error("pump rose without ctl");
    a_pump_off_cause: assert property ($fell(pump_on) |->
        $past(ctl_wr && !wdata[0])) else $error("pump fell without ctl");
    a_pgm_needs_lat: assert property ($rose(pump_on) |->
        $past(wdata[2])) else $error("pump rose with latch clear");
    a_both_clear_pgm: assert property (ctl_wr && pump_on &&
        !wdata[0] |=> !pump_on) else $error("pump stayed on");
    a_copy_reload: assert property (s_nvr_rd |->
        config_copy == rdata) else $error("copy not reloaded");
    a_copy_read: assert property (rd_stb &&
        addr == `EEP_ACR_ADDR |=> rdata == config_copy)
        else $error("copy read wrong");
    a_unmapped_zero: assert property (rd_stb && unmapped |=>
        rdata_vld && rdata == 8'h00) else $error("unmapped read");
    a_mode_frozen: assert property (pump_on ##1 pump_on |->
        $stable(erase_mode)) else $error("mode changed while pumping");
endmodule

// file: testbench/eeprom_byte_program_control_tb.sv
`timescale 1ns/10ps
// Drives the host over APB and reads the array back through it.
module eeprom_byte_program_control_tb;
    logic        core_clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pump_on;
    logic [7:0]  config_copy;
    logic [1:0]  erase_mode;
    logic        array_off;
    logic [31:0] rdat;
    logic        rerr;
    int          n_mismatch;
    int          samples_checked;

    eep_bus_if bus ();
    eep_host_ctl eep_host_ctl_inst (.core_clk, .rstn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus);
    eep_array_dev eep_array_dev_inst (.core_clk, .rstn, .bus, .pump_on,
        .config_copy, .erase_mode, .array_off);
    eep_monitor eep_monitor_inst (.core_clk, .rstn, .wr_stb(bus.wr_stb),
        .rd_stb(bus.rd_stb), .addr(bus.addr), .wdata(bus.wdata),
        .rdata(bus.rdata), .rdata_vld(bus.rdata_vld), .pump_on,
        .config_copy, .erase_mode);

    task give_verdict;
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Starts one host operation and polls busy until it is done.
    task op(input logic [1:0] o, input logic [1:0] m,
            input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, 8'h04, {16'h0000, a});
        apb(1'b1, 8'h08, {24'h000000, d});
        apb(1'b1, 8'h00, {23'h000000, 1'b1, 2'h0, m, 2'h0, o});
        do apb(1'b0, 8'h14, 32'h00000000); while (rdat[0] !== 1'b0);
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e);
        op(2'h1, 2'h0, a, 8'h00);
        chk("byte", e, rdat[15:8]);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // The run is short; this span is over thirty times the expected length.
    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        give_verdict;
    end

    // Reset, then programming, erase in every mode, and raw latch steps.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rstn = 1'b0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("copy", 8'h10, config_copy);
        rd(16'h0800, 8'hFF);
        rd(16'hFE1F, 8'h10);
        rd(16'hFE1C, 8'h10);
        apb(1'b1, 8'h0C, 32'h00000003);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk("hold", 8'h03, rdat[7:0]);
        apb(1'b0, 8'h18, 32'h00000000);
        chk("slverr", 8'h01, {7'h00, rerr});
        op(2'h0, 2'h0, 16'h0805, 8'hA5);
        rd(16'h0805, 8'hA5);
        op(2'h0, 2'h0, 16'h0805, 8'h5A);
        rd(16'h0805, 8'h00);
        op(2'h0, 2'h0, 16'h09FF, 8'h3C);
        rd(16'h09FF, 8'h3C);
        op(2'h0, 2'h1, 16'h0805, 8'h00);
        rd(16'h0805, 8'hFF);
        op(2'h0, 2'h2, 16'h0980, 8'h00);
        rd(16'h09FF, 8'hFF);
        op(2'h0, 2'h0, 16'h0800, 8'h0F);
        op(2'h0, 2'h3, 16'h0850, 8'h00);
        rd(16'h0800, 8'hFF);
        op(2'h2, 2'h0, 16'hFE1D, 8'h04);
        op(2'h2, 2'h0, 16'hFE1D, 8'h01);
        chk("pump", 8'h00, {7'h00, pump_on});
        op(2'h2, 2'h0, 16'h0810, 8'h77);
        rd(16'h0800, 8'h77);
        op(2'h2, 2'h0, 16'hFE1D, 8'h05);
        chk("pump", 8'h01, {7'h00, pump_on});
        op(2'h2, 2'h0, 16'hFE1D, 8'h00);
        rd(16'h0800, 8'h77);
        op(2'h2, 2'h0, 16'hFE1D, 8'h00);
        rd(16'h0810, 8'h77);
        rd(16'h0800, 8'hFF);
        rd(16'h0A00, 8'h00);
        op(2'h2, 2'h0, 16'hFE1D, 8'h20);
        chk("off", 8'h01, {7'h00, array_off});
        op(2'h2, 2'h0, 16'hFE1D, 8'h00);
        // Erase the config byte, so every block becomes protected.
        op(2'h0, 2'h1, 16'hFE1C, 8'h00);
        rd(16'hFE1C, 8'hFF);
        chk("copy", 8'hFF, config_copy);
        op(2'h0, 2'h0, 16'h0800, 8'h00);
        rd(16'h0800, 8'hFF);
        // Restore the config byte; a reset or a read of it makes the copy follow.
        op(2'h0, 2'h0, 16'hFE1C, 8'h10);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("copy", 8'h10, config_copy);
        op(2'h0, 2'h0, 16'h0800, 8'h5A);
        rd(16'h0800, 8'h5A);
        give_verdict;
    end
endmodule
